// *** bench/mfio_pin_model.sv ***
// pad model: resolves each pin from the block's drivers and the outside
`timescale 1ns/100ps
module mfio_pin_model
    import mfio_pkg::*;
(
    input  wire logic [B_W-1:0] b_o,
    input  wire logic [B_W-1:0] b_oe,
    input  wire logic [B_W-1:0] b_ext,
    output logic      [B_W-1:0] b_pin,
    input  wire logic [C_W-1:0] c_o,
    input  wire logic [C_W-1:0] c_oe,
    input  wire logic [C_W-1:0] c_ext,
    output logic      [C_W-1:0] c_pin,
    input  wire logic [D_W-1:0] d_o,
    input  wire logic [D_W-1:0] d_oe,
    input  wire logic [D_W-1:0] d_ext,
    output logic      [D_W-1:0] d_pin
);
    // undriven bits show the outside source, never the last driven value
    assign b_pin = (b_oe & b_o) | (~b_oe & b_ext);
    // three-pin lines: undriven bits take the outside level, high or low, like the other ports
    assign c_pin = (c_oe & c_o) | (~c_oe & c_ext);
    assign d_pin = (d_oe & d_o) | (~d_oe & d_ext);
endmodule : mfio_pin_model

// *** bench/mfio_ports_checker.sv ***
// assertions on pins and read-back of the io port block
`timescale 1ns/100ps
module mfio_ports_checker
    import mfio_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [AXI_DW-1:0] s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic [B_W-1:0]    port_b_pin_o,
    input wire logic [B_W-1:0]    port_b_pin_oe,
    input wire logic              stop_release_pin_i,
    input wire logic              stop_release_pin_oe,
    input wire logic              crystal_in_pin_oe,
    input wire logic              crystal_out_pin_oe,
    input wire logic [D_W-1:0]    port_d_pin_o,
    input wire logic [D_W-1:0]    port_d_pin_oe,
    input wire logic [D_W-1:0]    port_d_input_enable,
    input wire logic              low_freq_osc_en,
    input wire logic              ext_int_latch
);
    logic [5:0] ar_r;
    logic [7:0] rd8;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    assign rd8 = s_axi_rdata[7:0];

    // address of the read in flight, to know what rdata belongs to
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ar_r <= 6'h00;
        else if (s_axi_arvalid && s_axi_arready)
            ar_r <= s_axi_araddr[5:0];
    end

    a_rst_b_clear:
    assert property ($fell(sys_rst) |-> port_b_pin_o == 5'h00 && port_b_pin_oe == 5'h00)
        else $error("b port not cleared");
    a_rst_c_float:
    assert property ($fell(sys_rst)
        |-> !stop_release_pin_oe && !crystal_in_pin_oe && !crystal_out_pin_oe)
        else $error("c port driven after reset");
    a_rst_d_init:
    assert property ($fell(sys_rst) |-> port_d_pin_oe == 8'h00 && port_d_pin_o == 8'h00
        && port_d_input_enable == 8'hff)
        else $error("d port reset wrong");
    a_osc_xtal_free:
    assert property (low_freq_osc_en |-> !crystal_in_pin_oe && !crystal_out_pin_oe)
        else $error("crystal pin driven in dual mode");
    a_stop_fall_int:
    assert property ($fell(stop_release_pin_i) |-> ##[1:5] ext_int_latch)
        else $error("falling stop pin missed");
    a_b_rd_latch:
    assert property ($rose(s_axi_rvalid) && ar_r == OFS_B_LATCH && s_axi_rresp == RESP_OKAY
        |-> ((rd8[4:0] ^ port_b_pin_o) & port_b_pin_oe) == 5'h00)
        else $error("b output bit read differs from latch");
    a_d_rd_mix:
    assert property ($rose(s_axi_rvalid) && ar_r == OFS_D_LATCH
        |-> (((rd8 ^ port_d_pin_o) & port_d_pin_oe)
        | (rd8 & ~port_d_pin_oe & ~port_d_input_enable)) == 8'h00)
        else $error("d read mix wrong");
    a_b_upper_zero:
    assert property ($rose(s_axi_rvalid) && (ar_r == OFS_B_LATCH || ar_r == OFS_B_DIR)
        |-> rd8[7:5] == 3'h0)
        else $error("b upper bits not zero");

    c_int_set: cover property ($rose(ext_int_latch));
    c_dual: cover property ($rose(low_freq_osc_en));
    c_rd_err: cover property ($rose(s_axi_rvalid) && s_axi_rresp == RESP_SLVERR);
endmodule : mfio_ports_checker

bind mfio_ports mfio_ports_checker #(.ADDR_W(ADDR_W)) u_checker (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .port_b_pin_o(port_b_pin_o), .port_b_pin_oe(port_b_pin_oe),
    .stop_release_pin_i(stop_release_pin_i), .stop_release_pin_oe(stop_release_pin_oe),
    .crystal_in_pin_oe(crystal_in_pin_oe), .crystal_out_pin_oe(crystal_out_pin_oe),
    .port_d_pin_o(port_d_pin_o), .port_d_pin_oe(port_d_pin_oe),
    .port_d_input_enable(port_d_input_enable), .low_freq_osc_en(low_freq_osc_en),
    .ext_int_latch(ext_int_latch)
);

// *** bench/tb_top.sv ***
// self-checking bench for the multi-function io ports
`timescale 1ns/100ps
module tb_top
    import mfio_pkg::*;
;
    logic              sys_clk;
    logic              sys_rst;
    logic [5:0]        awaddr, araddr;
    logic              awvalid, wvalid, arvalid;
    logic [AXI_DW-1:0] wdata, rdv;
    logic [1:0]        rs;
    logic [B_W-1:0]    ext_b;
    logic [C_W-1:0]    ext_c;
    logic [D_W-1:0]    ext_d;
    wire               awready, wready, bvalid, arready, rvalid, osc_en, int_l;
    wire  [1:0]        bresp, rresp;
    wire  [AXI_DW-1:0] rdata;
    wire  [B_W-1:0]    b_o, b_oe, b_pin;
    wire  [C_W-1:0]    c_o, c_oe, c_pin;
    wire  [D_W-1:0]    d_o, d_oe, d_pin, d_ie;
    int                errors = 0;
    int                comparisons = 0;
    int                cyc = 0;

    // ready lines stay high: legal, and avoids re-driving them between transfers
    mfio_ports dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .port_b_pin_i(b_pin),
        .port_b_pin_o(b_o), .port_b_pin_oe(b_oe), .stop_release_pin_i(c_pin[0]),
        .stop_release_pin_o(c_o[0]), .stop_release_pin_oe(c_oe[0]),
        .crystal_in_pin_i(c_pin[1]), .crystal_in_pin_o(c_o[1]), .crystal_in_pin_oe(c_oe[1]),
        .crystal_out_pin_i(c_pin[2]), .crystal_out_pin_o(c_o[2]),
        .crystal_out_pin_oe(c_oe[2]), .port_d_pin_i(d_pin), .port_d_pin_o(d_o),
        .port_d_pin_oe(d_oe), .port_d_input_enable(d_ie), .low_freq_osc_en(osc_en),
        .ext_int_latch(int_l)
    );
    mfio_pin_model pins (
        .b_o(b_o), .b_oe(b_oe), .b_ext(ext_b), .b_pin(b_pin),
        .c_o(c_o), .c_oe(c_oe), .c_ext(ext_c), .c_pin(c_pin),
        .d_o(d_o), .d_oe(d_oe), .d_ext(ext_d), .d_pin(d_pin)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        begin
            $display("comparisons %0d errors %0d", comparisons, errors);
            if (errors == 0 && comparisons > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask : close_out

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        begin
            comparisons++;
            if (s !== e)
            begin
                errors++;
                $display("[ERR] %s expected %h seen %h", nm, e, s);
            end
        end
    endtask : chk

    // ready is sampled at the falling edge, so the item is released after its taking edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic aw_t;
        logic w_t;
        logic b_t;
        begin
            b_t = 1'b0;
            awaddr <= a;
            wdata <= {24'h000000, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            while (!b_t)
            begin
                @(negedge sys_clk);
                aw_t = awvalid && awready;
                w_t = wvalid && wready;
                b_t = bvalid;
                rs = bresp;
                @(posedge sys_clk);
                if (aw_t)
                    awvalid <= 1'b0;
                if (w_t)
                    wvalid <= 1'b0;
            end
        end
    endtask : wr

    task automatic rd(input logic [5:0] a);
        logic ar_t;
        logic r_t;
        begin
            r_t = 1'b0;
            araddr <= a;
            arvalid <= 1'b1;
            while (!r_t)
            begin
                @(negedge sys_clk);
                ar_t = arvalid && arready;
                r_t = rvalid;
                rdv = rdata;
                rs = rresp;
                @(posedge sys_clk);
                if (ar_t)
                    arvalid <= 1'b0;
            end
        end
    endtask : rd

    task automatic rd_chk(input string nm, input logic [5:0] a, input logic [7:0] e);
        begin
            rd(a);
            chk(nm, rdv[7:0], e);
        end
    endtask : rd_chk

    task automatic t_reset();
        begin
            chk("b oe", 8'(b_oe), 8'h00);
            chk("c oe", 8'(c_oe), 8'h00);
            chk("d ie", d_ie, 8'hff);
            rd_chk("b dir", OFS_B_DIR, 8'h00);
            rd_chk("b in", OFS_B_LATCH, 8'h0a);
            rd_chk("c latch", OFS_C_LATCH, 8'h07);
            rd_chk("d dir", OFS_D_DIR, 8'h00);
            rd_chk("d in en", OFS_D_IN_EN, 8'hff);
            rd_chk("d in", OFS_D_LATCH, 8'h5c);
            rd(6'h24);
            chk("bad rresp", {6'h00, rs}, {6'h00, RESP_SLVERR});
            wr(6'h24, 8'hff);
            chk("bad bresp", {6'h00, rs}, {6'h00, RESP_SLVERR});
            $display("reset test done");
        end
    endtask : t_reset

    task automatic t_port_b();
        begin
            wr(OFS_B_DIR, 8'hff);
            rd_chk("b latch", OFS_B_LATCH, 8'h00);
            rd_chk("b dir hi", OFS_B_DIR, 8'h1f);
            wr(OFS_B_LATCH, 8'h15);
            wr(OFS_B_DIR, 8'h0f);
            chk("b bresp", {6'h00, rs}, {6'h00, RESP_OKAY});
            chk("b out", 8'(b_o & b_oe), 8'h05);
            chk("b oe", 8'(b_oe), 8'h0f);
            repeat (3) @(posedge sys_clk);
            rd_chk("b mix", OFS_B_LATCH, 8'h05);
            // write-back of what was read loses the input bit's latch value
            wr(OFS_B_LATCH, rdv[7:0]);
            wr(OFS_B_DIR, 8'h1f);
            rd_chk("b rmw", OFS_B_LATCH, 8'h05);
            $display("b test done");
        end
    endtask : t_port_b

    task automatic t_port_c();
        begin
            wr(OFS_C_LATCH, 8'h06);
            chk("stop oe", 8'(c_oe), 8'h01);
            repeat (6) @(posedge sys_clk);
            chk("int", 8'(int_l), 8'h01);
            rd_chk("c latch", OFS_C_LATCH, 8'h06);
            rd_chk("c pins", OFS_C_PIN_RD, 8'h06);
            wr(OFS_STATUS, 8'h01);
            rd_chk("int clr", OFS_STATUS, 8'h00);
            wr(OFS_CTRL, 8'h05);
            chk("stop z", 8'(c_oe), 8'h00);
            wr(OFS_C_LATCH, 8'h00);
            chk("xtal io", 8'(c_oe), 8'h06);
            wr(OFS_CTRL, 8'h03);
            chk("osc", 8'(osc_en), 8'h01);
            chk("xtal off", 8'(c_oe), 8'h01);
            repeat (3) @(posedge sys_clk);
            rd_chk("c dual", OFS_C_PIN_RD, 8'h00);
            wr(OFS_CTRL, 8'h01);
            wr(OFS_C_LATCH, 8'h07);
            ext_c <= 3'h5;
            repeat (3) @(posedge sys_clk);
            rd_chk("c in", OFS_C_PIN_RD, 8'h05);
            $display("c test done");
        end
    endtask : t_port_c

    task automatic t_port_d();
        begin
            ext_d <= 8'hf0;
            wr(OFS_D_DIR, 8'h0f);
            wr(OFS_D_IN_EN, 8'h33);
            wr(OFS_D_LATCH, 8'ha5);
            chk("d ie", d_ie, 8'h30);
            chk("d oe", d_oe, 8'h0f);
            chk("d out", d_o & d_oe, 8'h05);
            repeat (3) @(posedge sys_clk);
            rd_chk("d mix", OFS_D_LATCH, 8'h35);
            $display("d test done");
        end
    endtask : t_port_d

    initial
    begin
        sys_rst = 1'b1;
        awaddr = 6'h00;
        araddr = 6'h00;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        wdata = 32'h00000000;
        ext_b = 5'h0a;
        ext_c = 3'h7;
        ext_d = 8'h5c;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_port_b();
        t_port_c();
        t_port_d();
        close_out();
    end
endmodule : tb_top

// *** core/mfio_pkg.sv ***
// shared constants for the multi-function io port block
package mfio_pkg;
    localparam int B_W = 5;
    localparam int C_W = 3;
    localparam int D_W = 8;
    localparam int REG_W = 8;
    localparam int AXI_DW = 32;
    localparam int MIN_ADDR_W = 6;

    localparam logic [5:0] OFS_B_LATCH   = 6'h00;
    localparam logic [5:0] OFS_B_DIR     = 6'h04;
    localparam logic [5:0] OFS_C_LATCH   = 6'h08;
    localparam logic [5:0] OFS_C_PIN_RD  = 6'h0c;
    localparam logic [5:0] OFS_D_LATCH   = 6'h10;
    localparam logic [5:0] OFS_D_DIR     = 6'h14;
    localparam logic [5:0] OFS_D_IN_EN   = 6'h18;
    localparam logic [5:0] OFS_CTRL      = 6'h1c;
    localparam logic [5:0] OFS_STATUS    = 6'h20;

    localparam logic [B_W-1:0] RST_B_LATCH = 5'h00;
    localparam logic [B_W-1:0] RST_B_DIR   = 5'h00;
    localparam logic [C_W-1:0] RST_C_LATCH = 3'h7;
    localparam logic [D_W-1:0] RST_D_LATCH = 8'h00;
    localparam logic [D_W-1:0] RST_D_DIR   = 8'h00;
    localparam logic [D_W-1:0] RST_D_IN_EN = 8'hff;

    // control register fields
    localparam int CTRL_OUT_EN  = 0;
    localparam int CTRL_DUAL    = 1;
    localparam int CTRL_STOP    = 2;
    localparam logic [2:0] RST_CTRL = 3'h1;
    // status register field
    localparam int STAT_EXT_INT = 0;
    // port c bit roles
    localparam int C_STOP_BIT = 0;
    localparam int C_XIN_BIT  = 1;
    localparam int C_XOUT_BIT = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mfio_pkg

// *** core/mfio_ports.sv ***
// three multi-function io ports behind an axi4-lite register slave
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Operation
// - five-pin port, each pin's direction set by its own direction bit
// - reset clears five-pin direction bits to input and its latch to 0
// - direction 1 drives the latch onto the pin; 0 leaves an input
// - five-pin data read returns the latch for output-direction bits
// - upper three bits of five-pin data and direction reads are undefined
// - input-mode bits read the pin, so write-back may overwrite their latch
// - three-pin port; its latch bits all set to 1 on reset
// - dual-clock mode gives upper two three-pin pins to the crystal
// - falling edge on the lowest three-pin pin sets the interrupt latch
// - three-pin latch and pin levels read at separate addresses
// - upper five bits of three-pin reads are undefined
// - stop mode floats the stop-release pin, whatever the output enable
// - eight-pin port; reset: direction 0, input-enable 1, latch 0
// - eight-pin read: 0, pin level or latch by direction and input-enable
// - writes change pins in the write cycle; reads sample pins at read; the code reads synchronised pins, two clocks late
module mfio_ports
    import mfio_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [AXI_DW-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // five-pin port
    input  wire logic [B_W-1:0]    port_b_pin_i,
    output logic      [B_W-1:0]    port_b_pin_o,
    output logic      [B_W-1:0]    port_b_pin_oe,
    // three-pin port, open-drain style drivers
    input  wire logic              stop_release_pin_i,
    output logic                   stop_release_pin_o,
    output logic                   stop_release_pin_oe,
    input  wire logic              crystal_in_pin_i,
    output logic                   crystal_in_pin_o,
    output logic                   crystal_in_pin_oe,
    input  wire logic              crystal_out_pin_i,
    output logic                   crystal_out_pin_o,
    output logic                   crystal_out_pin_oe,
    // eight-pin port
    input  wire logic [D_W-1:0]    port_d_pin_i,
    output logic      [D_W-1:0]    port_d_pin_o,
    output logic      [D_W-1:0]    port_d_pin_oe,
    output logic      [D_W-1:0]    port_d_input_enable,
    // system side
    output logic                   low_freq_osc_en,
    output logic                   ext_int_latch
);
    generate
        if (ADDR_W < MIN_ADDR_W)
        begin : g_bad_addr
            $error("mfio_ports: ADDR_W too small for the register map");
        end
        // every port must fit the one register byte that the bus carries
        if (REG_W < D_W || D_W < B_W || D_W < C_W || AXI_DW < REG_W)
        begin : g_bad_width
            $error("mfio_ports: port widths do not fit the register byte");
        end
    endgenerate

    typedef struct packed {
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [REG_W-1:0]  w_data;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [AXI_DW-1:0] rdata;
        logic [1:0]        rresp;
        logic [B_W-1:0]    b_latch;
        logic [B_W-1:0]    b_dir;
        logic [C_W-1:0]    c_latch;
        logic [D_W-1:0]    d_latch;
        logic [D_W-1:0]    d_dir;
        logic [D_W-1:0]    d_in_en;
        logic              out_en;
        logic              dual_clk;
        logic              stop_mode;
        logic              stop_prev;
        logic              ext_int;
    } mfio_state_type;

    mfio_state_type s_r;
    mfio_state_type s_nxt;

    logic [B_W-1:0] b_pin_s;
    logic [C_W-1:0] c_pin_s;
    logic [D_W-1:0] d_pin_s;

    // pins sit outside the clock domain
    mfio_sync #(.W(B_W)) u_sync_b (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d       (port_b_pin_i),
        .q       (b_pin_s)
    );

    mfio_sync #(.W(C_W)) u_sync_c (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d       ({crystal_out_pin_i, crystal_in_pin_i, stop_release_pin_i}),
        .q       (c_pin_s)
    );

    mfio_sync #(.W(D_W)) u_sync_d (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d       (port_d_pin_i),
        .q       (d_pin_s)
    );

    // per-bit data read: latch when output, pin when input enabled, else 0
    function automatic logic [D_W-1:0] port_read(
        input logic [D_W-1:0] dir,
        input logic [D_W-1:0] in_en,
        input logic [D_W-1:0] latch,
        input logic [D_W-1:0] pin
    );
        port_read = (dir & latch) | (~dir & in_en & pin);
    endfunction : port_read

    // address decode shared by the read and write paths
    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [5:0]        ofs
    );
        reg_hit = (addr == ADDR_W'(ofs));
    endfunction : reg_hit

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
        reg_mapped = reg_hit(addr, OFS_B_LATCH) | reg_hit(addr, OFS_B_DIR)
                   | reg_hit(addr, OFS_C_LATCH) | reg_hit(addr, OFS_C_PIN_RD)
                   | reg_hit(addr, OFS_D_LATCH) | reg_hit(addr, OFS_D_DIR)
                   | reg_hit(addr, OFS_D_IN_EN) | reg_hit(addr, OFS_CTRL)
                   | reg_hit(addr, OFS_STATUS);
    endfunction : reg_mapped

    logic [C_W-1:0] c_pin_view;
    logic           do_write;
    logic           do_read;
    logic           fall_evt;
    logic [REG_W-1:0] rd_byte;
    // five-pin read widened to the eight-bit read function; its input enable is always on
    logic [D_W-1:0]   b_rd_full;

    assign b_rd_full = port_read(D_W'(s_r.b_dir), {D_W{1'b1}}, D_W'(s_r.b_latch),
                                 D_W'(b_pin_s));

    always_comb
    begin
        // crystal pins read as 0 while the oscillator owns them
        c_pin_view = c_pin_s;
        if (s_r.dual_clk)
        begin
            c_pin_view[C_XIN_BIT]  = 1'b0;
            c_pin_view[C_XOUT_BIT] = 1'b0;
        end
    end

    assign s_axi_awready = !s_r.aw_held;
    assign s_axi_wready  = !s_r.w_held;
    assign s_axi_arready = !s_r.rvalid;
    assign do_write = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    assign do_read  = s_axi_arvalid && !s_r.rvalid;
    // the latch catches the pin level, so it also sees edges caused by our own drive
    // limitation: a pin pulse shorter than one clock may slip past the synchroniser
    assign fall_evt = s_r.stop_prev && !c_pin_s[C_STOP_BIT];

    // read data is sampled from the synchronised pins at the read handshake
    always_comb
    begin
        rd_byte = '0;
        if (reg_hit(s_axi_araddr, OFS_B_LATCH))
            rd_byte[B_W-1:0] = b_rd_full[B_W-1:0];
        else if (reg_hit(s_axi_araddr, OFS_B_DIR))
            rd_byte[B_W-1:0] = s_r.b_dir;
        else if (reg_hit(s_axi_araddr, OFS_C_LATCH))
            rd_byte[C_W-1:0] = s_r.c_latch;
        else if (reg_hit(s_axi_araddr, OFS_C_PIN_RD))
            rd_byte[C_W-1:0] = c_pin_view;
        else if (reg_hit(s_axi_araddr, OFS_D_LATCH))
            rd_byte = port_read(s_r.d_dir, s_r.d_in_en, s_r.d_latch, d_pin_s);
        else if (reg_hit(s_axi_araddr, OFS_D_DIR))
            rd_byte = s_r.d_dir;
        else if (reg_hit(s_axi_araddr, OFS_D_IN_EN))
            rd_byte = s_r.d_in_en;
        else if (reg_hit(s_axi_araddr, OFS_CTRL))
        begin
            rd_byte[CTRL_OUT_EN] = s_r.out_en;
            rd_byte[CTRL_DUAL]   = s_r.dual_clk;
            rd_byte[CTRL_STOP]   = s_r.stop_mode;
        end
        else if (reg_hit(s_axi_araddr, OFS_STATUS))
            rd_byte[STAT_EXT_INT] = s_r.ext_int;
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.stop_prev = c_pin_s[C_STOP_BIT];

        // write address and data may arrive in either order
        if (s_axi_awvalid && !s_r.aw_held)
        begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_held)
        begin
            s_nxt.w_held  = 1'b1;
            s_nxt.w_data  = s_axi_wdata[REG_W-1:0];
            s_nxt.w_lane0 = s_axi_wstrb[0];
        end
        if (s_r.bvalid && s_axi_bready)
            s_nxt.bvalid = 1'b0;

        if (do_write)
        begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = reg_mapped(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            // the pin-read register takes no write; a write there still answers okay
            // registers are one byte wide; only lane 0 carries them
            if (s_r.w_lane0)
            begin
                if (reg_hit(s_r.aw_addr, OFS_B_LATCH))
                    s_nxt.b_latch = s_r.w_data[B_W-1:0];
                if (reg_hit(s_r.aw_addr, OFS_B_DIR))
                    s_nxt.b_dir = s_r.w_data[B_W-1:0];
                if (reg_hit(s_r.aw_addr, OFS_C_LATCH))
                    s_nxt.c_latch = s_r.w_data[C_W-1:0];
                if (reg_hit(s_r.aw_addr, OFS_D_LATCH))
                    s_nxt.d_latch = s_r.w_data;
                if (reg_hit(s_r.aw_addr, OFS_D_DIR))
                    s_nxt.d_dir = s_r.w_data;
                if (reg_hit(s_r.aw_addr, OFS_D_IN_EN))
                    s_nxt.d_in_en = s_r.w_data;
                if (reg_hit(s_r.aw_addr, OFS_CTRL))
                begin
                    s_nxt.out_en    = s_r.w_data[CTRL_OUT_EN];
                    s_nxt.dual_clk  = s_r.w_data[CTRL_DUAL];
                    s_nxt.stop_mode = s_r.w_data[CTRL_STOP];
                end
                if (reg_hit(s_r.aw_addr, OFS_STATUS) && s_r.w_data[STAT_EXT_INT])
                    s_nxt.ext_int = 1'b0;
            end
        end
        // a new edge in the clearing cycle is kept
        if (fall_evt)
            s_nxt.ext_int = 1'b1;

        if (s_r.rvalid && s_axi_rready)
            s_nxt.rvalid = 1'b0;
        if (do_read)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = {{(AXI_DW-REG_W){1'b0}}, rd_byte};
            s_nxt.rresp  = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            s_r           <= '0;
            s_r.b_latch   <= RST_B_LATCH;
            s_r.b_dir     <= RST_B_DIR;
            s_r.c_latch   <= RST_C_LATCH;
            s_r.d_latch   <= RST_D_LATCH;
            s_r.d_dir     <= RST_D_DIR;
            s_r.d_in_en   <= RST_D_IN_EN;
            s_r.out_en    <= RST_CTRL[CTRL_OUT_EN];
            s_r.dual_clk  <= RST_CTRL[CTRL_DUAL];
            s_r.stop_mode <= RST_CTRL[CTRL_STOP];
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp  = s_r.bresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata  = s_r.rdata;
    assign s_axi_rresp  = s_r.rresp;

    // five-pin port: push-pull per direction bit
    assign port_b_pin_o  = s_r.b_latch;
    assign port_b_pin_oe = s_r.out_en ? s_r.b_dir : '0;

    // three-pin port pulls low only; a latch of 1 leaves the pin free
    assign stop_release_pin_o  = 1'b0;
    // stop mode releases this pin even while the global enable keeps the others
    assign stop_release_pin_oe = !s_r.stop_mode && s_r.out_en
                                 && !s_r.c_latch[C_STOP_BIT];
    assign crystal_in_pin_o    = 1'b0;
    assign crystal_in_pin_oe   = !s_r.dual_clk && s_r.out_en
                                 && !s_r.c_latch[C_XIN_BIT];
    assign crystal_out_pin_o   = 1'b0;
    assign crystal_out_pin_oe  = !s_r.dual_clk && s_r.out_en
                                 && !s_r.c_latch[C_XOUT_BIT];
    // the oscillator owns both crystal pins, hence their drivers are off above
    assign low_freq_osc_en     = s_r.dual_clk;

    // eight-pin port
    assign port_d_pin_o        = s_r.d_latch;
    assign port_d_pin_oe       = s_r.out_en ? s_r.d_dir : '0;
    assign port_d_input_enable = s_r.d_in_en & ~s_r.d_dir;

    assign ext_int_latch = s_r.ext_int;
endmodule : mfio_ports

// *** core/mfio_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module mfio_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } mfio_sync_type;

    mfio_sync_type s_r;
    mfio_sync_type s_nxt;

    always_comb
    begin
        s_nxt.meta   = d;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign q = s_r.stable;
endmodule : mfio_sync
